// [rtl/lpd_pkg.sv]
// How it works
// - chip select high ignores command lines
// - nop registers nothing, work continues
// - mode set only idle, then wait
// - mode set loads register from address
// - bank bits pick base or extended
// - activate opens row in chosen bank
// - activate first, then wait before access
// - precharge before new row, space activates
// - other-bank activates spaced by minimum
// - row stays open until precharged
// - read burst length, bank, column
// - address bit ten selects auto precharge
// - precharge all makes banks precharging
// - burst terminate cuts newest read burst
// - write after read only when done
// - rules hold with clock enable high
// - idle bank leaves others unconstrained
// - auto-precharge access limits other banks
// - auto precharge period start points
// - refresh and mode set need idle
// - controller avoids unlisted command combinations
// - data mask high discards write byte
package lpd_pkg;
  // ==========================================
  // geometry
  localparam int NBANK  = 4;
  localparam int BA_W   = 2;
  localparam int ADDR_W = 13;
  localparam int DQ_W   = 16;
  localparam int DM_W   = 2;
  localparam int CNT_W  = 5;
  localparam int AUTO_PRE_BIT = 10;
  localparam int BL_LSB = 0;
  // ==========================================
  // timing
  localparam int CLK_PS   = 25000;
  localparam int TRCD_NS  = 15;
  localparam int TRP_NS   = 15;
  localparam int TRC_NS   = 55;
  localparam int TRRD_NS  = 10;
  localparam int TWR_NS   = 15;
  localparam int TMRD_CYC = 2;
  localparam int TRCD_CYC = (TRCD_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int TRP_CYC  = (TRP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int TRC_CYC  = (TRC_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int TRRD_CYC = (TRRD_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int TWR_CYC  = (TWR_NS * 1000 + CLK_PS - 1) / CLK_PS;
  // ==========================================
  // mode register
  localparam logic [BA_W-1:0]   BA_MR   = 2'h0;
  localparam logic [BA_W-1:0]   BA_EMR  = 2'h2;
  localparam logic [ADDR_W-1:0] MR_RST  = 13'h0032;
  localparam logic [ADDR_W-1:0] EMR_RST = 13'h0000;
  // ==========================================
  // encodings
  typedef enum logic [2:0] {
    CMD_MRS = 3'h0, CMD_REF = 3'h1, CMD_PRE = 3'h2, CMD_ACT = 3'h3,
    CMD_WR  = 3'h4, CMD_RD  = 3'h5, CMD_BST = 3'h6, CMD_NOP = 3'h7
  } lpd_cmd_t;
  typedef enum logic [2:0] {
    BK_IDLE = 3'h0, BK_ACTIVATING = 3'h1, BK_ACTIVE = 3'h2,
    BK_READING = 3'h3, BK_WRITING = 3'h4, BK_PRECHARGING = 3'h5
  } lpd_bank_t;
  typedef enum logic [2:0] {
    OP_NOP = 3'h0, OP_ACT = 3'h1, OP_RD = 3'h2, OP_WR = 3'h3,
    OP_PRE = 3'h4, OP_PREA = 3'h5, OP_MRS = 3'h6, OP_BST = 3'h7
  } lpd_op_t;
  function automatic logic [CNT_W-1:0] lpd_burst_len(input logic [2:0] code);
    case (code)
      3'h1:    lpd_burst_len = 5'h02;
      3'h2:    lpd_burst_len = 5'h04;
      3'h3:    lpd_burst_len = 5'h08;
      3'h4:    lpd_burst_len = 5'h10;
      default: lpd_burst_len = 5'h04;
    endcase
  endfunction : lpd_burst_len
endpackage : lpd_pkg

// [rtl/lpd_if.sv]
interface lpd_if;
  import lpd_pkg::*;
  logic              cke;
  logic              cs_n;
  logic              ras_n;
  logic              cas_n;
  logic              we_n;
  logic [BA_W-1:0]   ba;
  logic [ADDR_W-1:0] addr;
  logic [DQ_W-1:0]   wr_dq;
  logic [DM_W-1:0]   dm;
  logic [DQ_W-1:0]   rd_dq;
  logic              rd_valid;
  modport host (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, wr_dq, dm,
                input rd_dq, rd_valid);
  modport dev  (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, wr_dq, dm,
                output rd_dq, rd_valid);
endinterface : lpd_if

// [rtl/lpd_bank.sv]
module lpd_bank
  import lpd_pkg::*;
#(
  parameter int TRCD = TRCD_CYC,
  parameter int TRP  = TRP_CYC,
  parameter int TWR  = TWR_CYC
)(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic act,
  input  wire logic rd,
  input  wire logic wr,
  input  wire logic pre,
  input  wire logic auto_pre,
  input  wire logic burst_end,
  output lpd_bank_t state,
  output logic      idle
);
  logic [CNT_W-1:0] cnt;
  logic             pend_pre;
  logic             wr_rec;

  assign idle = (state == BK_IDLE);

  // ==========================================
  // bank state machine
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state    <= BK_IDLE;
      cnt      <= '0;
      pend_pre <= 1'b0;
      wr_rec   <= 1'b0;
    end else begin
      case (state)
        BK_IDLE: begin
          if (act) begin
            state <= (TRCD > 1) ? BK_ACTIVATING : BK_ACTIVE;
            cnt   <= CNT_W'(TRCD - 1);
          end else if (pre) begin
            state <= BK_PRECHARGING;
            cnt   <= CNT_W'(TRP);
          end
        end
        BK_ACTIVATING: begin
          if (cnt <= 5'h01) state <= BK_ACTIVE;
          else cnt <= cnt - 5'h01;
        end
        BK_ACTIVE, BK_READING, BK_WRITING: begin
          if (rd || wr) begin
            state    <= rd ? BK_READING : BK_WRITING;
            pend_pre <= auto_pre;
            wr_rec   <= 1'b0;
          end else if (pre) begin
            state  <= BK_PRECHARGING;
            cnt    <= CNT_W'(TRP);
            wr_rec <= 1'b0;
          end else if (wr_rec) begin
            if (cnt <= 5'h01) begin
              state  <= BK_PRECHARGING;
              cnt    <= CNT_W'(TRP);
              wr_rec <= 1'b0;
            end else cnt <= cnt - 5'h01;
          end else if (burst_end && state != BK_ACTIVE) begin
            if (!pend_pre) state <= BK_ACTIVE;
            else if (state == BK_READING) begin
              state <= BK_PRECHARGING;
              cnt   <= CNT_W'(TRP);
            end else begin
              wr_rec <= 1'b1;
              cnt    <= CNT_W'(TWR);
            end
          end
        end
        BK_PRECHARGING: begin
          pend_pre <= 1'b0;
          if (cnt <= 5'h01) state <= BK_IDLE;
          else cnt <= cnt - 5'h01;
        end
        default: state <= BK_IDLE;
      endcase
    end
  end
endmodule : lpd_bank

// [rtl/lpd_dev.sv]
module lpd_dev
  import lpd_pkg::*;
#(
  parameter int COL_AW = 4,
  parameter int ROW_AW = 2
)(
  input  wire logic          clk,
  input  wire logic          rst_n,
  lpd_if.dev                 bus,
  output logic [ADDR_W-1:0]  mode_reg,
  output logic [ADDR_W-1:0]  ext_mode_reg,
  output logic [NBANK-1:0]   bank_open,
  output logic               cmd_error
);
  localparam int MEM_AW = BA_W + ROW_AW + COL_AW;

  logic                cke_q;
  logic                live;
  lpd_cmd_t            cmd;
  logic                is_act;
  logic                is_rd;
  logic                is_wr;
  logic                is_pre;
  logic                is_bst;
  logic                is_mrs;
  logic                is_ref;
  logic                auto_pre;
  logic [CNT_W-1:0]    bl;
  logic [NBANK-1:0]    sel;
  logic [NBANK-1:0]    b_act;
  logic [NBANK-1:0]    b_rd;
  logic [NBANK-1:0]    b_wr;
  logic [NBANK-1:0]    b_pre;
  logic [NBANK-1:0]    b_end;
  logic [NBANK-1:0]    b_idle;
  logic [NBANK-1:0]    b_ready;
  lpd_bank_t           b_state [NBANK];
  logic [ADDR_W-1:0]   row_q [NBANK];
  logic [DQ_W-1:0]     mem [2**MEM_AW];
  logic [CNT_W-1:0]    rd_cnt;
  logic [CNT_W-1:0]    wr_cnt;
  logic [BA_W-1:0]     rd_bank;
  logic [BA_W-1:0]     wr_bank;
  logic [COL_AW-1:0]   rd_col;
  logic [COL_AW-1:0]   wr_col;
  logic                rd_stop;
  logic                wr_stop;
  logic [CNT_W-1:0]    mrd_cnt;
  logic                bad;

  // ==========================================
  // command decode
  assign live     = bus.cke && cke_q && !bus.cs_n;
  assign cmd      = lpd_cmd_t'({bus.ras_n, bus.cas_n, bus.we_n});
  assign is_act   = live && cmd == CMD_ACT;
  assign is_rd    = live && cmd == CMD_RD;
  assign is_wr    = live && cmd == CMD_WR;
  assign is_pre   = live && cmd == CMD_PRE;
  assign is_bst   = live && cmd == CMD_BST;
  assign is_mrs   = live && cmd == CMD_MRS;
  assign is_ref   = live && cmd == CMD_REF;
  assign auto_pre = bus.addr[AUTO_PRE_BIT];
  assign bl       = lpd_burst_len(mode_reg[BL_LSB +: 3]);
  assign rd_stop  = is_bst || is_wr || (is_pre && (auto_pre || bus.ba == rd_bank));
  assign wr_stop  = is_rd || (is_pre && (auto_pre || bus.ba == wr_bank));

  always_ff @(posedge clk) begin
    if (!rst_n) cke_q <= 1'b0;
    else cke_q <= bus.cke;
  end

  // ==========================================
  // banks
  for (genvar g = 0; g < NBANK; g++) begin : g_bank
    assign sel[g]   = (bus.ba == BA_W'(g));
    assign b_act[g] = is_act && sel[g];
    assign b_rd[g]  = is_rd && sel[g];
    assign b_wr[g]  = is_wr && sel[g];
    assign b_pre[g] = is_pre && (sel[g] || auto_pre);
    assign b_end[g] = (rd_cnt != '0 && rd_bank == BA_W'(g) &&
                       (rd_cnt == 5'h01 || is_bst || ((is_rd || is_wr) && !sel[g]))) ||
                      (wr_cnt != '0 && wr_bank == BA_W'(g) &&
                       (wr_cnt == 5'h01 || ((is_rd || is_wr) && !sel[g])));
    assign b_ready[g] = b_state[g] == BK_ACTIVE || b_state[g] == BK_READING ||
                        b_state[g] == BK_WRITING;
    lpd_bank u_bank (
      .clk       (clk),
      .rst_n     (rst_n),
      .act       (b_act[g]),
      .rd        (b_rd[g]),
      .wr        (b_wr[g]),
      .pre       (b_pre[g]),
      .auto_pre  (auto_pre),
      .burst_end (b_end[g]),
      .state     (b_state[g]),
      .idle      (b_idle[g])
    );
    always_ff @(posedge clk) begin
      if (!rst_n) row_q[g] <= '0;
      else if (b_act[g]) row_q[g] <= bus.addr;
    end
  end

  // ==========================================
  // mode registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_reg     <= MR_RST;
      ext_mode_reg <= EMR_RST;
    end else if (is_mrs) begin
      if (bus.ba == BA_MR) mode_reg <= bus.addr;
      else if (bus.ba == BA_EMR) ext_mode_reg <= bus.addr;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) mrd_cnt <= '0;
    else if (is_mrs) mrd_cnt <= CNT_W'(TMRD_CYC - 1);
    else if (mrd_cnt != '0) mrd_cnt <= mrd_cnt - 5'h01;
  end

  // ==========================================
  // read burst engine
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_cnt  <= '0;
      rd_bank <= '0;
      rd_col  <= '0;
    end else if (is_rd) begin
      rd_cnt  <= bl;
      rd_bank <= bus.ba;
      rd_col  <= bus.addr[COL_AW-1:0];
    end else if (rd_stop) begin
      rd_cnt <= '0;
    end else if (rd_cnt != '0) begin
      rd_cnt <= rd_cnt - 5'h01;
      rd_col <= rd_col + COL_AW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus.rd_valid <= 1'b0;
      bus.rd_dq    <= '0;
    end else begin
      bus.rd_valid <= rd_cnt != '0 && !rd_stop;
      bus.rd_dq    <= mem[{rd_bank, row_q[rd_bank][ROW_AW-1:0], rd_col}];
    end
  end

  // ==========================================
  // write burst engine
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_cnt  <= '0;
      wr_bank <= '0;
      wr_col  <= '0;
    end else if (is_wr) begin
      wr_cnt  <= bl;
      wr_bank <= bus.ba;
      wr_col  <= bus.addr[COL_AW-1:0];
    end else if (wr_stop) begin
      wr_cnt <= '0;
    end else if (wr_cnt != '0) begin
      wr_cnt <= wr_cnt - 5'h01;
      wr_col <= wr_col + COL_AW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (wr_cnt != '0 && !wr_stop) begin
      for (int b = 0; b < DM_W; b++) begin
        if (!bus.dm[b]) begin
          mem[{wr_bank, row_q[wr_bank][ROW_AW-1:0], wr_col}][b*8 +: 8] <=
            bus.wr_dq[b*8 +: 8];
        end
      end
    end
  end

  // ==========================================
  // status
  always_comb begin
    bad = 1'b0;
    if (live && cmd != CMD_NOP && mrd_cnt != '0) bad = 1'b1;
    if ((is_rd || is_wr) && !(|(sel & b_ready))) bad = 1'b1;
    if (is_act && !(|(sel & b_idle))) bad = 1'b1;
    if ((is_mrs || is_ref) && !(&b_idle)) bad = 1'b1;
    if (is_mrs && (rd_cnt != '0 || wr_cnt != '0)) bad = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmd_error <= 1'b0;
      bank_open <= '0;
    end else begin
      cmd_error <= bad;
      bank_open <= ~b_idle;
    end
  end
endmodule : lpd_dev

// [rtl/lpd_host.sv]
module lpd_host
  import lpd_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  lpd_if.host                    bus,
  input  wire logic              req_valid,
  input  wire lpd_op_t           req_op,
  input  wire logic [BA_W-1:0]   req_ba,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DQ_W-1:0]   req_wdata,
  input  wire logic [DM_W-1:0]   req_wmask,
  output logic                   req_ready,
  output logic                   req_reject,
  output logic [DQ_W-1:0]        rd_data,
  output logic                   rd_valid
);
  logic [CNT_W-1:0] wait_cnt;
  logic [CNT_W-1:0] next_wait;
  logic [CNT_W-1:0] rc_cnt [NBANK];
  logic [NBANK-1:0] open;
  logic [NBANK-1:0] rc_busy;
  logic [CNT_W-1:0] bl;
  logic [CNT_W-1:0] wb_cnt;
  logic             wb_first;
  logic [DQ_W-1:0]  wb_data;
  logic [DM_W-1:0]  wb_mask;
  logic             take;
  logic             legal;
  logic             auto_pre;

  assign take     = req_valid && wait_cnt == '0;
  assign auto_pre = req_addr[AUTO_PRE_BIT];

  // ==========================================
  // legality and spacing
  always_comb begin
    case (req_op)
      OP_ACT:        legal = !open[req_ba] && rc_cnt[req_ba] == '0;
      OP_RD, OP_WR:  legal = open[req_ba];
      OP_MRS:        legal = open == '0 && rc_busy == '0;
      default:       legal = 1'b1;
    endcase
    next_wait = (wait_cnt != '0) ? wait_cnt - 5'h01 : '0;
    if (take && legal) begin
      case (req_op)
        OP_ACT:         next_wait = CNT_W'((TRCD_CYC > TRRD_CYC ? TRCD_CYC : TRRD_CYC) - 1);
        OP_RD:          next_wait = bl;
        OP_WR:          next_wait = bl + CNT_W'(TWR_CYC - 1);
        OP_PRE, OP_PREA: next_wait = CNT_W'(TRP_CYC - 1);
        OP_MRS:         next_wait = CNT_W'(TMRD_CYC - 1);
        default:        next_wait = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wait_cnt   <= '0;
      req_ready  <= 1'b0;
      req_reject <= 1'b0;
      bl         <= lpd_burst_len(MR_RST[BL_LSB +: 3]);
    end else begin
      wait_cnt   <= next_wait;
      req_ready  <= next_wait == '0;
      req_reject <= take && !legal;
      if (take && legal && req_op == OP_MRS && req_ba == BA_MR)
        bl <= lpd_burst_len(req_addr[BL_LSB +: 3]);
    end
  end

  // ==========================================
  // bank tracking
  for (genvar g = 0; g < NBANK; g++) begin : g_trk
    assign rc_busy[g] = rc_cnt[g] != '0;
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        open[g]   <= 1'b0;
        rc_cnt[g] <= '0;
      end else if (take && legal && (req_ba == BA_W'(g) || req_op == OP_PREA)) begin
        case (req_op)
          OP_ACT: begin
            open[g]   <= 1'b1;
            rc_cnt[g] <= CNT_W'(TRC_CYC - 1);
          end
          OP_RD, OP_WR: if (auto_pre) begin
            open[g]   <= 1'b0;
            rc_cnt[g] <= bl + CNT_W'(TRP_CYC) +
                         ((req_op == OP_WR) ? CNT_W'(TWR_CYC) : '0);
          end
          OP_PRE, OP_PREA: begin
            open[g]   <= 1'b0;
            rc_cnt[g] <= CNT_W'(TRP_CYC);
          end
          default: ;
        endcase
      end else if (rc_cnt[g] != '0) begin
        rc_cnt[g] <= rc_cnt[g] - 5'h01;
      end
    end
  end

  // ==========================================
  // command pins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus.cke   <= 1'b0;
      bus.cs_n  <= 1'b1;
      {bus.ras_n, bus.cas_n, bus.we_n} <= CMD_NOP;
      bus.ba    <= '0;
      bus.addr  <= '0;
    end else begin
      bus.cke   <= 1'b1;
      bus.cs_n  <= !(take && legal && req_op != OP_NOP);
      bus.ba    <= req_ba;
      bus.addr  <= req_addr;
      case (req_op)
        OP_ACT:          {bus.ras_n, bus.cas_n, bus.we_n} <= CMD_ACT;
        OP_RD:           {bus.ras_n, bus.cas_n, bus.we_n} <= CMD_RD;
        OP_WR:           {bus.ras_n, bus.cas_n, bus.we_n} <= CMD_WR;
        OP_PRE, OP_PREA: {bus.ras_n, bus.cas_n, bus.we_n} <= CMD_PRE;
        OP_MRS:          {bus.ras_n, bus.cas_n, bus.we_n} <= CMD_MRS;
        OP_BST:          {bus.ras_n, bus.cas_n, bus.we_n} <= CMD_BST;
        default:         {bus.ras_n, bus.cas_n, bus.we_n} <= CMD_NOP;
      endcase
      if (req_op == OP_PREA) bus.addr[AUTO_PRE_BIT] <= 1'b1;
      else if (req_op == OP_PRE) bus.addr[AUTO_PRE_BIT] <= 1'b0;
    end
  end

  // ==========================================
  // write beats and read return
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wb_cnt   <= '0;
      wb_first <= 1'b0;
      wb_data  <= '0;
      wb_mask  <= '0;
      bus.wr_dq <= '0;
      bus.dm   <= '1;
    end else if (take && legal && req_op == OP_WR) begin
      wb_cnt   <= bl;
      wb_first <= 1'b1;
      wb_data  <= req_wdata;
      wb_mask  <= req_wmask;
      bus.dm   <= '1;
    end else if (wb_cnt != '0) begin
      wb_cnt    <= wb_cnt - 5'h01;
      wb_first  <= 1'b0;
      bus.wr_dq <= wb_data;
      bus.dm    <= wb_first ? ~wb_mask : '1;
    end else begin
      bus.dm <= '1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_valid <= 1'b0;
      rd_data  <= '0;
    end else begin
      rd_valid <= bus.rd_valid;
      rd_data  <= bus.rd_dq;
    end
  end
endmodule : lpd_host

// [test/lpd_properties.sv]
module lpd_properties
  import lpd_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              cke,
  input wire logic              cs_n,
  input wire logic              ras_n,
  input wire logic              cas_n,
  input wire logic              we_n,
  input wire logic [BA_W-1:0]   ba,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DQ_W-1:0]   wr_dq,
  input wire logic [DM_W-1:0]   dm,
  input wire logic [DQ_W-1:0]   rd_dq,
  input wire logic              rd_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // helper state
  logic       cke_q;
  logic [4:0] age;
  logic [4:0] bl;
  logic [2:0] cmd;
  logic       sel;
  logic       quiet;
  assign cmd   = {ras_n, cas_n, we_n};
  assign sel   = cke && cke_q && !cs_n;
  assign quiet = !sel || cmd == CMD_NOP;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cke_q <= 1'b0;
    end else begin
      cke_q <= cke;
    end
  end
  // cycles since the last read command
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      age <= 5'h1f;
    end else if (sel && cmd == CMD_RD) begin
      age <= 5'h01;
    end else if (age != 5'h1f) begin
      age <= age + 5'h01;
    end
  end
  // burst length from base mode register writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bl <= 5'h04;
    end else if (sel && cmd == CMD_MRS && ba == BA_MR) begin
      bl <= (addr[2:0] >= 3'h1 && addr[2:0] <= 3'h4) ? 5'h01 << addr[2:0] : 5'h04;
    end
  end
  // ==========================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_rd;  sel && cmd == CMD_RD;  endsequence
  sequence s_wr;  sel && cmd == CMD_WR;  endsequence
  sequence s_act; sel && cmd == CMD_ACT; endsequence
  sequence s_mrs; sel && cmd == CMD_MRS; endsequence
  sequence s_no_reopen;
    !(sel && cmd == CMD_ACT && ba == $past(ba))
    ##1 !(sel && cmd == CMD_ACT && ba == $past(ba, 2));
  endsequence
  property p_cke_first;  !cs_n |-> cke && $past(cke);                  endproperty
  property p_rd_start;   s_rd |=> ##1 rd_valid;                        endproperty
  property p_rd_window;  rd_valid |-> age >= 5'h02 && age <= bl + 5'h01; endproperty
  property p_rd_hold;    rd_valid && age <= bl && quiet |=> rd_valid;  endproperty
  property p_rd_end;     rd_valid && age == bl + 5'h01 && quiet |=> !rd_valid; endproperty
  property p_mrs_gap;    s_mrs |=> quiet;                              endproperty
  property p_mrs_idle;   s_mrs |-> age > bl;                           endproperty
  property p_wr_after_rd; s_wr |-> age > bl;                           endproperty
  property p_trc;        s_act |=> s_no_reopen;                        endproperty
  a_cke_first: assert property (p_cke_first)
    else $error("command without two enabled edges");
  a_rd_start: assert property (p_rd_start)
    else $error("read gave no beat");
  a_rd_window: assert property (p_rd_window)
    else $error("beat outside a read burst");
  a_rd_hold: assert property (p_rd_hold)
    else $error("burst broken by idle command");
  a_rd_end: assert property (p_rd_end)
    else $error("burst longer than mode length");
  a_mrs_gap: assert property (p_mrs_gap)
    else $error("command inside mode set wait");
  a_mrs_idle: assert property (p_mrs_idle)
    else $error("mode set during burst");
  a_wr_after_rd: assert property (p_wr_after_rd)
    else $error("write before read data done");
  a_trc: assert property (p_trc)
    else $error("same bank activated too soon");
endmodule : lpd_properties

// [test/test_lpddr_bank_command_rules.sv]
module test_lpddr_bank_command_rules
  import lpd_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk;
  logic              rst_n;
  logic              req_valid;
  lpd_op_t           req_op;
  logic [BA_W-1:0]   req_ba;
  logic [ADDR_W-1:0] req_addr;
  logic [DQ_W-1:0]   req_wdata;
  logic [DM_W-1:0]   req_wmask;
  logic              req_ready;
  logic              req_reject;
  logic [DQ_W-1:0]   rd_data;
  logic              rd_valid;
  logic [ADDR_W-1:0] mode_reg;
  logic [ADDR_W-1:0] ext_mode_reg;
  logic [NBANK-1:0]  bank_open;
  logic              cmd_error;
  logic [DQ_W-1:0]   rq[$];
  int                errors = 0;
  int                total_checks = 0;
  int                rejects = 0;
  int                faults = 0;
  int                cycles = 0;
  // ==========================================
  // instances
  lpd_if lpd_if_inst ();
  lpd_dev lpd_dev_inst (.clk(clk), .rst_n(rst_n), .bus(lpd_if_inst), .mode_reg(mode_reg),
    .ext_mode_reg(ext_mode_reg), .bank_open(bank_open), .cmd_error(cmd_error));
  lpd_host lpd_host_inst (.clk(clk), .rst_n(rst_n), .bus(lpd_if_inst),
    .req_valid(req_valid), .req_op(req_op), .req_ba(req_ba), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_wmask(req_wmask), .req_ready(req_ready),
    .req_reject(req_reject), .rd_data(rd_data), .rd_valid(rd_valid));
  lpd_properties lpd_properties_inst (.clk(clk), .rst_n(rst_n), .cke(lpd_if_inst.cke),
    .cs_n(lpd_if_inst.cs_n), .ras_n(lpd_if_inst.ras_n), .cas_n(lpd_if_inst.cas_n),
    .we_n(lpd_if_inst.we_n), .ba(lpd_if_inst.ba), .addr(lpd_if_inst.addr),
    .wr_dq(lpd_if_inst.wr_dq), .dm(lpd_if_inst.dm), .rd_dq(lpd_if_inst.rd_dq),
    .rd_valid(lpd_if_inst.rd_valid));
  // ==========================================
  // clock and monitors
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (rd_valid === 1'b1) rq.push_back(rd_data);
    if (req_reject === 1'b1) rejects <= rejects + 1;
    if (cmd_error === 1'b1) faults <= faults + 1;
    if (cycles == 4000) begin
      errors++;
      close_out();
    end
  end
  // ==========================================
  // tasks
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic req(input lpd_op_t op, input logic [BA_W-1:0] b, input logic [ADDR_W-1:0] a,
                     input logic [DQ_W-1:0] d = 16'h0000, input logic [DM_W-1:0] m = 2'h3);
    int n;
    n = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req_op    <= op;
    req_ba    <= b;
    req_addr  <= a;
    req_wdata <= d;
    req_wmask <= m;
    do begin
      @(posedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 64);
    req_valid <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : req
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input int bl);
    rq.delete();
    req(OP_RD, 2'h1, a);
    check("beats", 16'(rq.size()), 16'(bl));
    check("beat0", rq[0], 16'ha5c3);
    check("beat1", rq[1], 16'hff34);
  endtask : rd_chk
  task automatic close_out();
    if (errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out
  // ==========================================
  // main sequence
  initial begin
    rst_n     = 1'b0;
    req_valid = 1'b0;
    req_op    = OP_NOP;
    req_ba    = 2'h0;
    req_addr  = 13'h0000;
    req_wdata = 16'h0000;
    req_wmask = 2'h0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    check("mode_reg", 16'(mode_reg), 16'(MR_RST));
    check("ext_mode_reg", 16'(ext_mode_reg), 16'(EMR_RST));
    req(OP_MRS, BA_MR, 13'h0021);
    req(OP_MRS, BA_EMR, 13'h0005);
    check("mode_reg", 16'(mode_reg), 16'h0021);
    check("ext_mode_reg", 16'(ext_mode_reg), 16'h0005);
    req(OP_NOP, 2'h1, 13'h0002);
    check("bank_open", 16'(bank_open), 16'h0000);
    req(OP_ACT, 2'h1, 13'h0002);
    req(OP_ACT, 2'h2, 13'h0001);
    check("bank_open", 16'(bank_open), 16'h0006);
    req(OP_MRS, BA_MR, 13'h0032);
    req(OP_ACT, 2'h2, 13'h0000);
    req(OP_RD, 2'h0, 13'h0000);
    check("rejects", 16'(rejects), 16'h0003);
    check("mode_reg", 16'(mode_reg), 16'h0021);
    check("beats", 16'(rq.size()), 16'h0000);
    req(OP_WR, 2'h1, 13'h0003, 16'ha5c3, 2'h3);
    req(OP_WR, 2'h1, 13'h0004, 16'hffff, 2'h3);
    req(OP_WR, 2'h1, 13'h0004, 16'h1234, 2'h1);
    rd_chk(13'h0003, 2);
    check("bank_open", 16'(bank_open), 16'h0006);
    rd_chk(13'h0403, 2);
    check("bank_open", 16'(bank_open), 16'h0004);
    req(OP_PREA, 2'h0, 13'h0400);
    check("bank_open", 16'(bank_open), 16'h0000);
    req(OP_MRS, BA_MR, 13'h0032);
    check("mode_reg", 16'(mode_reg), 16'h0032);
    req(OP_ACT, 2'h1, 13'h0002);
    rd_chk(13'h0003, 4);
    req(OP_BST, 2'h3, 13'h0000);
    check("bank_open", 16'(bank_open), 16'h0002);
    check("cmd_error", 16'(faults), 16'h0000);
    close_out();
  end
endmodule : test_lpddr_bank_command_rules
